// ---- rtl/bade_exec.sv ----
// execution datapath for decimal adjust of the accumulator and decrement of a file byte
// assumes instruction requests and register port come from logic on ref_clk
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - low nibble above nine or nibble carry set: add six to low nibble
// - low nibble nine or less and nibble carry clear: low nibble unchanged
// - high nibble above nine or carry set: add six there, carry becomes one
// - decimal adjust works on all eight accumulator bits, result to accumulator
// - decrement with destination zero writes result to accumulator, file untouched
// - decrement with destination one writes result back to the file byte
// - access select zero maps the file operand into the access bank
// - access select one joins bank pointer and file operand into the address
// - extended mode, access zero, operand up to 95: indexed literal offset address
module bade_exec
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // instruction request
    input wire logic instr_valid,
    input wire logic instr_op,
    input wire logic [7:0] instr_file,
    input wire logic instr_dest,
    input wire logic instr_access,
    // register port
    input wire logic [bade_pkg::BADE_RA_W-1:0] reg_addr,
    input wire logic [bade_pkg::BADE_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [bade_pkg::BADE_DW-1:0] reg_rdata_q,
    // execution state
    output logic busy_q,
    output logic done_q
);
    import bade_pkg::*;

    bade_phase_t phase_q, phase_d;
    logic [7:0] acc_q;
    logic [7:0] status_q;
    logic [3:0] bank_select_pointer_q;
    logic ext_en_q;
    logic [11:0] idx_q;
    logic [11:0] maddr_q;
    logic op_q;
    logic dest_q;
    logic [11:0] eaddr_q;
    logic [7:0] result_q;
    logic [7:0] flags_q;
    logic [7:0] mem_q;

    // phase sequencer, a request is taken only while idle
    wire start = instr_valid && (phase_q == BADE_IDLE);
    always_comb
    begin
        case (phase_q)
            BADE_IDLE: phase_d = start ? BADE_Q1 : BADE_IDLE;
            BADE_Q1: phase_d = BADE_Q2;
            BADE_Q2: phase_d = BADE_Q3;
            BADE_Q3: phase_d = BADE_Q4;
            BADE_Q4: phase_d = BADE_IDLE;
            default: phase_d = BADE_IDLE;
        endcase
    end

    // effective address selection
    wire in_access_lo = (instr_file <= BADE_ACC_SPLIT);
    wire use_indexed = ext_en_q && !instr_access && in_access_lo;
    wire [11:0] idx_addr = idx_q + {4'h0, instr_file};
    wire [3:0] acc_bank = in_access_lo ? BADE_ACC_LO_BANK : BADE_ACC_HI_BANK;
    wire [11:0] bank_addr = {bank_select_pointer_q, instr_file};
    wire [11:0] eaddr_d = use_indexed ? idx_addr :
        (instr_access ? bank_addr : {acc_bank, instr_file});

    // operand of this instruction, memory read data stand in the third phase
    wire [7:0] opnd = (op_q == BADE_OP_ADJ) ? acc_q : mem_q;

    // decimal adjust, high nibble tested after the low fix so its carry is counted
    wire lo_fix = (opnd[3:0] > BADE_BCD_MAX) || status_q[BADE_ST_NCF];
    wire [8:0] lo_sum = {1'b0, opnd} + (lo_fix ? BADE_ADJ_LO : 9'h000);
    wire hi_fix = lo_sum[8] || (lo_sum[7:4] > BADE_BCD_MAX) || status_q[BADE_ST_C];
    wire [8:0] adj_sum = lo_sum + (hi_fix ? BADE_ADJ_HI : 9'h000);
    wire adj_c = hi_fix | adj_sum[8];

    // decrement arithmetic and flags
    wire [7:0] dec_res = opnd - 8'h01;
    wire dec_c = (opnd != 8'h00);
    wire dec_nc = (opnd[3:0] != 4'h0);
    wire dec_vf = (opnd == 8'h80);
    wire dec_z = (dec_res == 8'h00);
    wire [7:0] dec_flags = {3'b000, dec_res[7], dec_vf, dec_z, dec_nc, dec_c};
    wire [7:0] adj_flags = {status_q[7:1], adj_c};
    wire [7:0] res_d = (op_q == BADE_OP_ADJ) ? adj_sum[7:0] : dec_res;
    wire [7:0] flags_d = (op_q == BADE_OP_ADJ) ? adj_flags : dec_flags;

    // writes in the fourth phase
    wire in_q4 = (phase_q == BADE_Q4);
    wire to_acc = in_q4 && ((op_q == BADE_OP_ADJ) || !dest_q);
    wire to_file = in_q4 && (op_q == BADE_OP_DEC) && dest_q;
    wire idle = (phase_q == BADE_IDLE);
    wire bus_mem_wr = reg_wr && (reg_addr == BADE_OFS_MDATA) && idle;
    wire mem_we = to_file || bus_mem_wr;
    wire [11:0] mem_waddr = to_file ? eaddr_q : maddr_q;
    wire [7:0] mem_wdata = to_file ? result_q : reg_wdata;
    wire [11:0] mem_raddr = (phase_q == BADE_Q2) ? eaddr_q : maddr_q;

    bade_dmem u_general_purpose_ram
    (
        .ref_clk(ref_clk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata_q(mem_q)
    );

    // register port write decode
    wire wr_acc = reg_wr && (reg_addr == BADE_OFS_ACC);
    wire wr_status = reg_wr && (reg_addr == BADE_OFS_STATUS);
    wire wr_bank = reg_wr && (reg_addr == BADE_OFS_BANK);
    wire wr_ctrl = reg_wr && (reg_addr == BADE_OFS_CTRL);
    wire wr_idx_lo = reg_wr && (reg_addr == BADE_OFS_IDX_LO);
    wire wr_idx_hi = reg_wr && (reg_addr == BADE_OFS_IDX_HI);
    wire wr_ma_lo = reg_wr && (reg_addr == BADE_OFS_MADDR_LO);
    wire wr_ma_hi = reg_wr && (reg_addr == BADE_OFS_MADDR_HI);

    // execution results win over a register port write in the same cycle
    wire [7:0] acc_d = to_acc ? result_q : (wr_acc ? reg_wdata : acc_q);
    wire [7:0] status_d = in_q4 ? flags_q :
        (wr_status ? (reg_wdata & BADE_ST_MASK) : status_q);

    // read data selection, unmapped offsets read zero
    logic [7:0] rd_mux;
    always_comb
    begin
        case (reg_addr)
            BADE_OFS_ACC: rd_mux = acc_q;
            BADE_OFS_STATUS: rd_mux = status_q;
            BADE_OFS_BANK: rd_mux = {4'h0, bank_select_pointer_q};
            BADE_OFS_CTRL: rd_mux = {7'h00, ext_en_q};
            BADE_OFS_IDX_LO: rd_mux = idx_q[7:0];
            BADE_OFS_IDX_HI: rd_mux = {4'h0, idx_q[11:8]};
            BADE_OFS_MADDR_LO: rd_mux = maddr_q[7:0];
            BADE_OFS_MADDR_HI: rd_mux = {4'h0, maddr_q[11:8]};
            BADE_OFS_MDATA: rd_mux = mem_q;
            BADE_OFS_STATE: rd_mux = {6'h00, done_q, busy_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // sequencer and software-visible registers
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            phase_q <= BADE_IDLE;
            acc_q <= BADE_RST_ACC;
            status_q <= BADE_RST_STATUS;
            bank_select_pointer_q <= BADE_RST_BANK;
            ext_en_q <= 1'b0;
            idx_q <= BADE_RST_IDX;
            maddr_q <= BADE_RST_MADDR;
            reg_rdata_q <= 8'h00;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            phase_q <= phase_d;
            acc_q <= acc_d;
            status_q <= status_d;
            if (wr_bank)
            begin
                bank_select_pointer_q <= reg_wdata[3:0];
            end
            if (wr_ctrl)
            begin
                ext_en_q <= reg_wdata[BADE_CTRL_EXT];
            end
            if (wr_idx_lo)
            begin
                idx_q[7:0] <= reg_wdata;
            end
            if (wr_idx_hi)
            begin
                idx_q[11:8] <= reg_wdata[3:0];
            end
            if (wr_ma_lo)
            begin
                maddr_q[7:0] <= reg_wdata;
            end
            if (wr_ma_hi)
            begin
                maddr_q[11:8] <= reg_wdata[3:0];
            end
            reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
            busy_q <= (phase_d != BADE_IDLE);
            done_q <= in_q4;
        end
    end

    // operand capture per phase: decode, read, process
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            op_q <= BADE_OP_ADJ;
            dest_q <= 1'b1;
            eaddr_q <= 12'h000;
            result_q <= 8'h00;
            flags_q <= 8'h00;
        end
        else
        begin
            if (start)
            begin
                op_q <= instr_op;
                dest_q <= instr_dest;
                eaddr_q <= eaddr_d;
            end
            if (phase_q == BADE_Q3)
            begin
                result_q <= res_d;
                flags_q <= flags_d;
            end
        end
    end
endmodule

// ---- rtl/bade_pkg.sv ----
// shared constants for the bcd adjust and decrement execution datapath
// assumes a single 20 MHz core clock and a plain register port with 4-bit addresses
package bade_pkg;
    // register port geometry
    localparam int BADE_RA_W = 4;
    localparam int BADE_DW = 8;
    localparam int BADE_MA_W = 12;
    // register offsets
    localparam logic [3:0] BADE_OFS_ACC = 4'h0;
    localparam logic [3:0] BADE_OFS_STATUS = 4'h1;
    localparam logic [3:0] BADE_OFS_BANK = 4'h2;
    localparam logic [3:0] BADE_OFS_CTRL = 4'h3;
    localparam logic [3:0] BADE_OFS_IDX_LO = 4'h4;
    localparam logic [3:0] BADE_OFS_IDX_HI = 4'h5;
    localparam logic [3:0] BADE_OFS_MADDR_LO = 4'h6;
    localparam logic [3:0] BADE_OFS_MADDR_HI = 4'h7;
    localparam logic [3:0] BADE_OFS_MDATA = 4'h8;
    localparam logic [3:0] BADE_OFS_STATE = 4'h9;
    // status field positions
    localparam int BADE_ST_C = 0;
    localparam int BADE_ST_NCF = 1;
    localparam int BADE_ST_Z = 2;
    localparam int BADE_ST_OVF = 3;
    localparam int BADE_ST_N = 4;
    localparam logic [7:0] BADE_ST_MASK = 8'h1f;
    // control field positions
    localparam int BADE_CTRL_EXT = 0;
    // reset values
    localparam logic [7:0] BADE_RST_ACC = 8'h00;
    localparam logic [7:0] BADE_RST_STATUS = 8'h00;
    localparam logic [3:0] BADE_RST_BANK = 4'h0;
    localparam logic [11:0] BADE_RST_IDX = 12'h000;
    localparam logic [11:0] BADE_RST_MADDR = 12'h000;
    // addressing and decimal adjust constants
    localparam logic [7:0] BADE_ACC_SPLIT = 8'h5f;
    localparam logic [3:0] BADE_ACC_LO_BANK = 4'h0;
    localparam logic [3:0] BADE_ACC_HI_BANK = 4'hf;
    localparam logic [3:0] BADE_BCD_MAX = 4'h9;
    localparam logic [8:0] BADE_ADJ_LO = 9'h006;
    localparam logic [8:0] BADE_ADJ_HI = 9'h060;
    // opcode select
    localparam logic BADE_OP_ADJ = 1'b0;
    localparam logic BADE_OP_DEC = 1'b1;
    // phase sequencer
    typedef enum logic [2:0] {BADE_IDLE, BADE_Q1, BADE_Q2, BADE_Q3, BADE_Q4} bade_phase_t;
endpackage

// ---- rtl/bade_dmem.sv ----
// data memory for the execution datapath, one write and one registered read port
// assumes write and read addresses come from logic on the same clock
`timescale 1ns/1ps
module bade_dmem
(
    // clock
    input wire logic ref_clk,
    // write port
    input wire logic we,
    input wire logic [bade_pkg::BADE_MA_W-1:0] waddr,
    input wire logic [bade_pkg::BADE_DW-1:0] wdata,
    // read port
    input wire logic [bade_pkg::BADE_MA_W-1:0] raddr,
    output logic [bade_pkg::BADE_DW-1:0] rdata_q
);
    import bade_pkg::*;
    logic [BADE_DW-1:0] mem [0:(1<<BADE_MA_W)-1];

    // store on write, read data registered one cycle after the address
    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
        rdata_q <= mem[raddr];
    end
endmodule

// ---- tb/bade_exec_asserts.sv ----
// port timing checks for the execution datapath
// assumes binding onto bade_exec, one clock domain
`timescale 1ns/1ps
module bade_exec_asserts
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // request and register port
    input wire logic instr_valid,
    input wire logic reg_rd,
    input wire logic [bade_pkg::BADE_RA_W-1:0] reg_addr,
    input wire logic [bade_pkg::BADE_DW-1:0] reg_rdata_q,
    // execution state
    input wire logic busy_q,
    input wire logic done_q
);
    import bade_pkg::*;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    // four busy phases, then a lone done cycle
    sequence s_run;
        busy_q [*4] ##1 (done_q && !busy_q);
    endsequence
    property p_take; instr_valid && !busy_q |=> busy_q; endproperty
    property p_run; $rose(busy_q) |-> s_run; endproperty
    property p_cause; $rose(busy_q) |-> $past(instr_valid); endproperty
    property p_done_once; done_q |=> !done_q; endproperty
    property p_done_after; done_q |-> $past(busy_q, 4) && $past(busy_q); endproperty
    property p_quiet; !$past(reg_rd) |-> reg_rdata_q == 8'h00; endproperty
    property p_state;
        reg_rd && reg_addr == BADE_OFS_STATE |=>
            reg_rdata_q == {6'h00, $past(done_q), $past(busy_q)};
    endproperty
    property p_status;
        reg_rd && reg_addr == BADE_OFS_STATUS |=> reg_rdata_q[7:5] == 3'h0;
    endproperty
    // one check per timing relation
    a_take: assert property (p_take) else $error("request not taken");
    a_run: assert property (p_run) else $error("phase run wrong");
    a_cause: assert property (p_cause) else $error("busy without request");
    a_done_once: assert property (p_done_once) else $error("done too long");
    a_done_after: assert property (p_done_after) else $error("done early");
    a_quiet: assert property (p_quiet) else $error("read data not idle");
    a_state: assert property (p_state) else $error("state read wrong");
    a_status: assert property (p_status) else $error("status spare bits set");
endmodule

bind bade_exec bade_exec_asserts u_chk
(
    .ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata_q(reg_rdata_q), .busy_q(busy_q), .done_q(done_q)
);

// ---- tb/bcd_adjust_and_decrement_exec_tb_top.sv ----
// self-checking bench for the execution datapath
// assumes bade_exec with its memory, clock at 20 MHz
`timescale 1ns/1ps
module bcd_adjust_and_decrement_exec_tb_top;
    import bade_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic instr_valid = 1'b0, instr_op = 1'b0, instr_dest = 1'b0, instr_access = 1'b0;
    logic [7:0] instr_file = 8'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_rdata_q;
    logic busy_q, done_q;
    logic [31:0] seed = 32'h2719;
    int n_fail = 0;
    int compares = 0;
    // clock of 50 ns period
    always #25 ref_clk = ~ref_clk;
    bade_exec DUT
    (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_file(instr_file), .instr_dest(instr_dest), .instr_access(instr_access),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .busy_q(busy_q), .done_q(done_q)
    );
    // repeatable random source
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // carry and accumulator expected after decimal adjust
    function logic [8:0] adj_exp(input logic [7:0] w, input logic c, input logic nc);
        logic [8:0] t;
        t = {1'b0, w};
        if (w[3:0] > 4'h9 || nc) t = t + 9'h006;
        if (t[8] || t[7:4] > 4'h9 || c) t = {1'b1, t[7:0] + 8'h60};
        else t[8] = c;
        return t;
    endfunction
    // byte comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // register port cycles
    task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [7:0] dt);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= ad;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 dt = reg_rdata_q;
    endtask
    // one instruction, request held into busy to be refused, done timed
    task automatic exec(input logic op, input logic [7:0] f, input logic d, input logic ac);
        logic [7:0] n;
        n = 8'h00;
        @(posedge ref_clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        instr_file <= f;
        instr_dest <= d;
        instr_access <= ac;
        @(posedge ref_clk);
        @(posedge ref_clk);
        instr_valid <= 1'b0;
        while (n < 8'h10 && done_q !== 1'b1)
        begin
            @(posedge ref_clk);
            #1 n++;
        end
        // done four edges after the taking edge, counted from the edge after it
        chk(n, 8'h03);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_fail++;
        $display("Error %0t watchdog expired", $time);
        finish_test();
    end
    // main sequence
    initial
    begin
        logic [7:0] v, f, st, got;
        logic [8:0] e;
        logic [11:0] ad;
        logic [31:0] r;
        logic d;
        int i, a, b, s;
        repeat (3) @(posedge ref_clk);
        sys_rst <= 1'b0;
        for (i = 0; i < 18; i++)
        begin
            r = rnd();
            a = r[7:0] % 100;
            b = r[15:8] % 100;
            s = (a / 10 + b / 10) * 16 + a % 10 + b % 10;
            v = (i == 0) ? 8'ha5 : (i == 1) ? 8'hce : s[7:0];
            st = {3'h0, r[18:16], (i > 1) && (a % 10 + b % 10 > 15), (i > 1) && s[8]};
            wr(BADE_OFS_ACC, v);
            wr(BADE_OFS_STATUS, st);
            exec(1'b0, r[27:20], r[28], r[29]);
            e = adj_exp(v, st[0], st[1]);
            rd(BADE_OFS_ACC, got);
            chk(got, e[7:0]);
            rd(BADE_OFS_STATUS, got);
            chk(got, {st[7:1], e[8]});
            rd(BADE_OFS_STATE, got);
            chk(got, 8'h00);
        end
        $display("test decimal adjust done");
        for (i = 0; i < 24; i++)
        begin
            r = rnd();
            v = (i < 4) ? 8'h00 : (i < 8) ? 8'h80 : (i < 12) ? 8'h10 : r[7:0];
            a = i % 4;
            d = (i / 4) % 2;
            f = (a == 2) ? r[15:8] % 8'h60 : (a == 3) ? 8'h60 + r[15:8] % 8'ha0 : r[15:8];
            if (a == 0) ad = {r[19:16], f};
            else if (a == 2) ad = r[31:20] + {4'h0, f};
            else ad = {(f > 8'h5f) ? 4'hf : 4'h0, f};
            wr(BADE_OFS_BANK, {4'h0, r[19:16]});
            wr(BADE_OFS_CTRL, {7'h00, a > 1});
            wr(BADE_OFS_IDX_LO, r[27:20]);
            wr(BADE_OFS_IDX_HI, {4'h0, r[31:28]});
            wr(BADE_OFS_MADDR_LO, ad[7:0]);
            wr(BADE_OFS_MADDR_HI, {4'h0, ad[11:8]});
            wr(BADE_OFS_MDATA, v);
            wr(BADE_OFS_ACC, ~v);
            exec(1'b1, f, d, a == 0);
            e = {1'b0, v - 8'h01};
            rd(BADE_OFS_ACC, got);
            chk(got, d ? ~v : e[7:0]);
            rd(BADE_OFS_MDATA, got);
            chk(got, d ? e[7:0] : v);
            rd(BADE_OFS_STATUS, got);
            chk(got, {3'h0, e[7], v == 8'h80, v == 8'h01, v[3:0] != 4'h0, v != 8'h00});
        end
        $display("test decrement done");
        finish_test();
    end
endmodule
